//--- sfc_cfg.svh
// Register indices, field positions, reset values and timing counts.
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SFC_IDX_SYS_OUT      7'h01
`define SFC_IDX_CPU_OUT      7'h03
`define SFC_IDX_SYS_TGT      7'h05
`define SFC_IDX_CPU_TGT      7'h06
`define SFC_IDX_TOL          7'h07
`define SFC_IDX_SYS_STOP     7'h08
`define SFC_IDX_CPU_STOP     7'h09
`define SFC_IDX_SYS_START    7'h0A
`define SFC_IDX_CPU_START    7'h0B
`define SFC_IDX_SYS_STIME    7'h0C
`define SFC_IDX_CPU_STIME    7'h0D
`define SFC_IDX_PACE_E       7'h0E
`define SFC_IDX_PACE_F       7'h0F
`define SFC_IDX_KEEP_MIN     7'h12
`define SFC_IDX_MODE         7'h13
`define SFC_IDX_STATUS       7'h14
`define SFC_IDX_SYS_TEMP     7'h27
`define SFC_IDX_SRC_SEL      7'h49
`define SFC_IDX_CPU_TEMP_W   7'h50
`define SFC_IDX_CPU_TEMP_H   7'h51
`define SFC_IDX_MAX_OUT      7'h67
`define SFC_IDX_STEP         7'h68

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SFC_KEEP_SYS_BIT     5
`define SFC_KEEP_CPU_BIT     4
`define SFC_MODE_SYS_LSB     0
`define SFC_MODE_CPU_LSB     2

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define SFC_OUT_RESET        8'hFF
`define SFC_CFG_RESET        8'h00
`define SFC_RESP_OKAY        2'h0
`define SFC_RESP_SLVERR      2'h2

// ----------------------------------------------------------------------
// Timing: one pacing unit of 100 ms at a 10 ns clock
// ----------------------------------------------------------------------
`define SFC_CLK_PERIOD_NS    10
`define SFC_UNIT_MS          100
`define SFC_UNIT_CYC         ((`SFC_UNIT_MS * 1000000) / `SFC_CLK_PERIOD_NS)

`endif

//--- sfc_pkg.sv
// Types shared by the fan controller.
package sfc_pkg;

  // Automatic mode of one fan output.
  typedef enum logic [1:0]
  {
    SFC_MODE_MANUAL = 2'b00,
    SFC_MODE_HOLD   = 2'b01,
    SFC_MODE_STEP   = 2'b10
  } sfc_mode_e;

  // Stepped-target sequencer state.
  typedef enum logic
  {
    SFC_ST_RUN  = 1'b0,
    SFC_ST_STOP = 1'b1
  } sfc_step_state_e;

  // A comparison of a measurement against a window.
  typedef struct packed
  {
    logic above;
    logic below;
  } sfc_win_s;

endpackage

//--- sfc_ctrl.sv
// Closed-loop fan output controller with an AXI4-Lite register slave.
//
// Behaviour
// - Speed-hold runs two independent loops: system tach/drive, CPU tach/drive.
// - Speed-hold regulates the pulse-period count against target plus/minus tolerance.
// - Count inside the window leaves the fan output unchanged.
// - Count above the window raises the fan output.
// - Count below the window lowers the fan output.
// - Stepped-target drives only the CPU fan, temperature from source select.
// - Temperature within working target plus/minus tolerance holds the output.
// - Too hot: output up one step, working target up by tolerance.
// - Step-up repeats against each new target, stopping at the maximum.
// - Too cold: output down one step, working target down by tolerance.
// - Step-down repeats against each new target, stopping at the minimum.
// - The step amount comes from the separate output-step register.
// - Persistent cold ramps output to zero, or stop value when enabled.
// - Once at the stop value, output holds there for the stop time.
`timescale 1ns/10ps

`include "sfc_cfg.svh"

module sfc_ctrl
  import sfc_pkg::*;
#(
  parameter int unsigned UNIT_CYC = `SFC_UNIT_CYC
)
(
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write address and data
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          awaddr,
  input  wire logic [2:0]           awprot,
  input  wire logic                 wvalid,
  output logic                      wready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  // AXI4-Lite write response
  output logic                      bvalid,
  input  wire logic                 bready,
  output logic [1:0]                bresp,
  // AXI4-Lite read
  input  wire logic                 arvalid,
  output logic                      arready,
  input  wire logic [31:0]          araddr,
  input  wire logic [2:0]           arprot,
  output logic                      rvalid,
  input  wire logic                 rready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  // Measured tachometer period counts
  input  wire logic [7:0]           sys_fan_tach_in,
  input  wire logic [7:0]           cpu_fan_tach_in,
  // Temperatures
  input  wire logic [7:0]           sys_temp_input,
  input  wire logic [7:0][7:0]      temp_src_whole,
  input  wire logic [7:0]           temp_src_half,
  // Fan drive levels
  output logic [7:0]                sys_fan_drive,
  output logic [7:0]                cpu_fan_drive
);

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------

  // Adds with a ceiling.
  function automatic logic [7:0] sat_add(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [7:0] lim);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = (s > {1'b0, lim}) ? lim : s[7:0];
  endfunction

  // Subtracts with a floor.
  function automatic logic [7:0] sat_sub(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [7:0] fl);
    logic [8:0] s;
    s = {1'b0, a} - {1'b0, b};
    sat_sub = (s[8] || s[7:0] < fl) ? fl : s[7:0];
  endfunction

  // Compares a value against centre plus/minus tolerance.
  function automatic sfc_win_s win_cmp(input logic [7:0] v,
                                       input logic [7:0] ctr,
                                       input logic [3:0] tol);
    win_cmp.above = {1'b0, v} > ({1'b0, ctr} + {5'h00, tol});
    win_cmp.below = ({1'b0, v} + {5'h00, tol}) < {1'b0, ctr};
  endfunction

  // Marks indices that answer on the bus.
  function automatic logic idx_mapped(input logic [6:0] i);
    unique case (i)
      `SFC_IDX_SYS_OUT, `SFC_IDX_CPU_OUT, `SFC_IDX_SYS_TGT,
      `SFC_IDX_CPU_TGT, `SFC_IDX_TOL, `SFC_IDX_SYS_STOP,
      `SFC_IDX_CPU_STOP, `SFC_IDX_SYS_START, `SFC_IDX_CPU_START,
      `SFC_IDX_SYS_STIME, `SFC_IDX_CPU_STIME, `SFC_IDX_PACE_E,
      `SFC_IDX_PACE_F, `SFC_IDX_KEEP_MIN, `SFC_IDX_MODE,
      `SFC_IDX_STATUS, `SFC_IDX_SYS_TEMP, `SFC_IDX_SRC_SEL,
      `SFC_IDX_CPU_TEMP_W, `SFC_IDX_CPU_TEMP_H, `SFC_IDX_MAX_OUT,
      `SFC_IDX_STEP: idx_mapped = 1'b1;
      default: idx_mapped = 1'b0;
    endcase
  endfunction

  // Marks the read-only indices.
  function automatic logic idx_ro(input logic [6:0] i);
    idx_ro = (i == `SFC_IDX_STATUS) || (i == `SFC_IDX_SYS_TEMP) ||
             (i == `SFC_IDX_CPU_TEMP_W) || (i == `SFC_IDX_CPU_TEMP_H);
  endfunction

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  logic [7:0]          cfg_r [0:127];
  logic [7:0]          sys_out_r;
  logic [7:0]          cpu_out_r;
  logic [7:0]          work_tgt_r;
  sfc_step_state_e     st_r;
  logic [7:0]          hold_cnt_r;
  logic [31:0]         unit_cnt_r;
  logic [7:0]          pace_s_r;
  logic [7:0]          pace_c_r;
  logic                aw_full_r;
  logic                w_full_r;
  logic [6:0]          aw_idx_r;
  logic [7:0]          w_data_r;
  logic                w_lane_r;
  logic                awready_r;
  logic                wready_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                arready_r;
  logic                rvalid_r;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------

  // Write is performed once address and data are both held.
  wire       aw_take  = awvalid && awready_r;
  wire       w_take   = wvalid && wready_r;
  wire       do_write = aw_full_r && w_full_r && !bvalid_r;
  wire       wr_ok    = idx_mapped(aw_idx_r) && !idx_ro(aw_idx_r);
  wire       wr_en    = do_write && wr_ok && w_lane_r;
  wire       aw_full_nxt = !do_write && (aw_full_r || aw_take);
  wire       w_full_nxt  = !do_write && (w_full_r || w_take);
  wire       bvalid_nxt  = do_write || (bvalid_r && !bready);
  wire       ar_take  = arvalid && arready_r;
  wire       rvalid_nxt  = ar_take || (rvalid_r && !rready);
  wire [6:0] ar_idx   = araddr[8:2];
  wire       ar_ok    = (araddr[31:9] == 23'h000000) && idx_mapped(ar_idx);
  wire       aw_hi_ok = (awaddr[31:9] == 23'h000000);

  // --------------------------------------------------------------------
  // Configuration fields
  // --------------------------------------------------------------------

  // Mode, tolerances, floors and the selected temperature.
  wire sfc_mode_e mode_s = sfc_mode_e'(cfg_r[`SFC_IDX_MODE][1:0]);
  wire sfc_mode_e mode_c = sfc_mode_e'(cfg_r[`SFC_IDX_MODE][3:2]);
  wire [3:0] tol_s   = cfg_r[`SFC_IDX_TOL][3:0];
  wire [3:0] tol_c   = cfg_r[`SFC_IDX_TOL][7:4];
  wire       keep_s  = cfg_r[`SFC_IDX_KEEP_MIN][`SFC_KEEP_SYS_BIT];
  wire       keep_c  = cfg_r[`SFC_IDX_KEEP_MIN][`SFC_KEEP_CPU_BIT];
  wire [7:0] floor_s = keep_s ? cfg_r[`SFC_IDX_SYS_STOP] : 8'h00;
  wire [7:0] floor_c = keep_c ? cfg_r[`SFC_IDX_CPU_STOP] : 8'h00;
  wire [2:0] src_sel = cfg_r[`SFC_IDX_SRC_SEL][2:0];
  wire [7:0] cpu_temp = temp_src_whole[src_sel];
  wire [7:0] t_up    = cfg_r[`SFC_IDX_PACE_F];
  wire [7:0] t_dn    = cfg_r[`SFC_IDX_PACE_E];
  wire [7:0] step_v  = cfg_r[`SFC_IDX_STEP];
  wire [7:0] max_c   = cfg_r[`SFC_IDX_MAX_OUT];
  wire [7:0] tol_c8  = {4'h0, tol_c};

  // --------------------------------------------------------------------
  // Pacing
  // --------------------------------------------------------------------

  // A unit tick paces every automatic change and the stop hold.
  wire       tick   = (unit_cnt_r == UNIT_CYC - 1);
  wire       up_s_ok = tick && (pace_s_r >= t_up);
  wire       dn_s_ok = tick && (pace_s_r >= t_dn);
  wire       up_c_ok = tick && (pace_c_r >= t_up);
  wire       dn_c_ok = tick && (pace_c_r >= t_dn);

  // --------------------------------------------------------------------
  // Speed-hold loops
  // --------------------------------------------------------------------

  // Each fan compares its own tach count with its own window.
  wire sfc_win_s win_s = win_cmp(sys_fan_tach_in,
                                 cfg_r[`SFC_IDX_SYS_TGT], tol_s);
  wire sfc_win_s win_h = win_cmp(cpu_fan_tach_in,
                                 cfg_r[`SFC_IDX_CPU_TGT], tol_c);
  wire hs_up = (mode_s == SFC_MODE_HOLD) && win_s.above && up_s_ok;
  wire hs_dn = (mode_s == SFC_MODE_HOLD) && win_s.below && dn_s_ok;
  wire hc_up = (mode_c == SFC_MODE_HOLD) && win_h.above && up_c_ok;
  wire hc_dn = (mode_c == SFC_MODE_HOLD) && win_h.below && dn_c_ok;

  // --------------------------------------------------------------------
  // Stepped-target loop
  // --------------------------------------------------------------------

  // The working target follows the programmed one until the mode runs.
  wire       in_step = (mode_c == SFC_MODE_STEP);
  wire sfc_win_s win_t = win_cmp(cpu_temp, work_tgt_r, tol_c);
  wire       holding = (st_r == SFC_ST_STOP);
  wire       st_up = in_step && !holding && win_t.above &&
                     (cpu_out_r < max_c) && up_c_ok;
  wire       st_dn = in_step && !holding && win_t.below &&
                     (cpu_out_r > floor_c) && dn_c_ok;
  wire [7:0] st_dn_val = sat_sub(cpu_out_r, step_v, floor_c);
  wire       reach_stop = st_dn && keep_c && (st_dn_val == floor_c);

  // Next output and target values; unchanged inside the window.
  wire       chg_s   = hs_up || hs_dn;
  wire       chg_c   = hc_up || hc_dn || st_up || st_dn;
  wire [7:0] sys_out_nxt =
    hs_up ? sat_add(sys_out_r, 8'h01, 8'hFF) :
    hs_dn ? sat_sub(sys_out_r, 8'h01, floor_s) :
    (wr_en && aw_idx_r == `SFC_IDX_SYS_OUT) ? w_data_r : sys_out_r;
  wire [7:0] cpu_out_nxt =
    hc_up ? sat_add(cpu_out_r, 8'h01, 8'hFF) :
    hc_dn ? sat_sub(cpu_out_r, 8'h01, floor_c) :
    st_up ? sat_add(cpu_out_r, step_v, max_c) :
    st_dn ? st_dn_val :
    (wr_en && aw_idx_r == `SFC_IDX_CPU_OUT) ? w_data_r : cpu_out_r;
  wire [7:0] work_tgt_nxt =
    !in_step ? cfg_r[`SFC_IDX_CPU_TGT] :
    st_up ? sat_add(work_tgt_r, tol_c8, 8'hFF) :
    st_dn ? sat_sub(work_tgt_r, tol_c8, 8'h00) : work_tgt_r;

  // Stop hold: entered on reaching the stop value, left when time runs out.
  wire       hold_go   = reach_stop && (cfg_r[`SFC_IDX_CPU_STIME] != 8'h00);
  wire       hold_done = holding && tick && (hold_cnt_r <= 8'h01);
  wire sfc_step_state_e st_nxt =
    !in_step  ? SFC_ST_RUN :
    hold_go   ? SFC_ST_STOP :
    hold_done ? SFC_ST_RUN : st_r;
  wire [7:0] hold_cnt_nxt =
    hold_go ? cfg_r[`SFC_IDX_CPU_STIME] :
    (holding && tick) ? hold_cnt_r - 8'h01 : hold_cnt_r;

  // --------------------------------------------------------------------
  // Read-back
  // --------------------------------------------------------------------

  // Live values for status and temperature indices.
  wire [7:0] rd_byte =
    (ar_idx == `SFC_IDX_SYS_OUT)    ? sys_out_r :
    (ar_idx == `SFC_IDX_CPU_OUT)    ? cpu_out_r :
    (ar_idx == `SFC_IDX_STATUS)     ? {6'h00, holding, in_step} :
    (ar_idx == `SFC_IDX_SYS_TEMP)   ? sys_temp_input :
    (ar_idx == `SFC_IDX_CPU_TEMP_W) ? cpu_temp :
    (ar_idx == `SFC_IDX_CPU_TEMP_H) ? {temp_src_half[src_sel], 7'h00} :
    (ar_idx == `SFC_IDX_CPU_START + 7'h0B) ? work_tgt_r :
    cfg_r[ar_idx];

  // --------------------------------------------------------------------
  // Write channel handshakes
  // --------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      awready_r <= !aw_full_nxt;
      wready_r  <= !w_full_nxt;
      bvalid_r  <= bvalid_nxt;
    end
  end

  // Captures the write payload and the response code.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_idx_r <= 7'h00;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      bresp_r  <= `SFC_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_idx_r <= aw_hi_ok ? awaddr[8:2] : 7'h7F;
      if (w_take)
      begin
        w_data_r <= wdata[7:0];
        w_lane_r <= wstrb[0];
      end
      if (do_write)
        bresp_r <= wr_ok ? `SFC_RESP_OKAY : `SFC_RESP_SLVERR;
    end
  end

  // --------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= `SFC_RESP_OKAY;
    end
    else
    begin
      arready_r <= !rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take)
      begin
        rdata_r <= ar_ok ? {24'h000000, rd_byte} : 32'h00000000;
        rresp_r <= ar_ok ? `SFC_RESP_OKAY : `SFC_RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------------
  // Configuration registers written by software
  // --------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 128; i++)
        cfg_r[i] <= `SFC_CFG_RESET;
    end
    else if (wr_en)
      cfg_r[aw_idx_r] <= w_data_r;
  end

  // --------------------------------------------------------------------
  // Unit timer and pacing counters
  // --------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unit_cnt_r <= 32'h00000000;
      pace_s_r   <= 8'h00;
      pace_c_r   <= 8'h00;
    end
    else
    begin
      unit_cnt_r <= tick ? 32'h00000000 : unit_cnt_r + 32'h00000001;
      if (chg_s)
        pace_s_r <= 8'h00;
      else if (tick && pace_s_r != 8'hFF)
        pace_s_r <= pace_s_r + 8'h01;
      if (chg_c)
        pace_c_r <= 8'h00;
      else if (tick && pace_c_r != 8'hFF)
        pace_c_r <= pace_c_r + 8'h01;
    end
  end

  // --------------------------------------------------------------------
  // Fan outputs, working target and stop hold
  // --------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sys_out_r  <= `SFC_OUT_RESET;
      cpu_out_r  <= `SFC_OUT_RESET;
      work_tgt_r <= `SFC_CFG_RESET;
      st_r       <= SFC_ST_RUN;
      hold_cnt_r <= 8'h00;
    end
    else
    begin
      sys_out_r  <= sys_out_nxt;
      cpu_out_r  <= cpu_out_nxt;
      work_tgt_r <= work_tgt_nxt;
      st_r       <= st_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  // Every output comes straight from a flip-flop.
  assign awready       = awready_r;
  assign wready        = wready_r;
  assign bvalid        = bvalid_r;
  assign bresp         = bresp_r;
  assign arready       = arready_r;
  assign rvalid        = rvalid_r;
  assign rdata         = rdata_r;
  assign rresp         = rresp_r;
  assign sys_fan_drive = sys_out_r;
  assign cpu_fan_drive = cpu_out_r;

endmodule

//--- sfc_ctrl_properties.sv
// Bus handshake and fan drive pacing assertions for the fan controller.
`timescale 1ns/10ps

module sfc_ctrl_checker
#(
  parameter int unsigned UNIT_CYC = 8
)
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  // Read channels
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  // Fan drives
  input wire logic [7:0]  sys_fan_drive,
  input wire logic [7:0]  cpu_fan_drive
);

  logic [7:0]  cpu_prev_r;
  logic        bv_prev_r;
  logic [15:0] cpu_gap_r;
  logic        cpu_auto;

  // A drive change that no write response explains came from the loop.
  assign cpu_auto = (cpu_fan_drive != cpu_prev_r) && !(bvalid && !bv_prev_r);

  // Counts cycles since the last loop-made change of the CPU drive.
  always_ff @(posedge aclk)
  begin
    cpu_prev_r <= cpu_fan_drive;
    bv_prev_r  <= bvalid;
    if (!aresetn || cpu_auto)
      cpu_gap_r <= (!aresetn) ? 16'hFFFF : 16'h0000;
    else if (cpu_gap_r != 16'hFFFF)
      cpu_gap_r <= cpu_gap_r + 16'h0001;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_state: assert property ($rose(aresetn) |-> !bvalid && !rvalid
    && sys_fan_drive == 8'hFF && cpu_fan_drive == 8'hFF)
    else $error("outputs not at reset values");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped early");
  a_wr_answer: assert property (awvalid && awready && wvalid && wready
    |-> ##[1:2] bvalid) else $error("write response late");
  a_rd_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read response late");
  a_b_cause: assert property ($rose(bvalid) |-> !$past(awready)
    && !$past(wready)) else $error("write response without a write");
  a_r_cause: assert property ($rose(rvalid) |-> $past(arvalid)
    && $past(arready)) else $error("read response without a read");
  a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_err_data: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
    else $error("refused read returned data");
  a_cpu_paced: assert property (
    cpu_auto |-> cpu_gap_r >= UNIT_CYC - 1)
    else $error("CPU drive changed between ticks");
  a_sys_paced: assert property (
    $changed(sys_fan_drive) && !$rose(bvalid)
    |=> $stable(sys_fan_drive)[*3]) else $error("system drive changed twice");

endmodule

bind sfc_ctrl sfc_ctrl_checker #(.UNIT_CYC(UNIT_CYC)) u_chk (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid,
  .arready, .rvalid, .rready, .rdata, .rresp, .sys_fan_drive, .cpu_fan_drive);

//--- sfc_fan_model.sv
// Behavioural fan that turns a drive level into a tachometer period count.
`timescale 1ns/10ps

module sfc_fan_model
(
  // Clock
  input  wire logic       aclk,
  // Drive in, period count out
  input  wire logic [7:0] drive,
  output logic      [7:0] tach
);

  // A harder-driven fan spins faster, so its pulse period count falls.
  always_ff @(posedge aclk)
  begin
    tach <= 8'hFF - drive;
  end

endmodule

//--- tb_closed_loop_fan_speed_control.sv
// Self-checking bench for the closed-loop fan controller.
`timescale 1ns/10ps

`define CHK(nm, e, a) \
  samples_checked++; \
  if ((a) !== (e)) \
  begin \
    $display("unexpected %s exp %h got %h", nm, e, a); \
    error_cnt++; \
  end

module tb_closed_loop_fan_speed_control
  import sfc_pkg::*;
;
  localparam int unsigned UC = 8;
  logic            aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic            awready, wready, bvalid, arready, rvalid;
  logic [31:0]     awaddr, wdata, araddr, rdata;
  logic [1:0]      bresp, rresp;
  logic [7:0][7:0] temp_src_whole;
  logic [7:0]      sys_fan_drive, cpu_fan_drive;
  logic [7:0]      sys_fan_tach_in, cpu_fan_tach_in;
  int              error_cnt, samples_checked;

  sfc_ctrl #(.UNIT_CYC(UC)) dut (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
    .rdata, .rresp, .sys_fan_tach_in, .cpu_fan_tach_in,
    .sys_temp_input(8'h2A), .temp_src_whole, .temp_src_half(8'h00),
    .sys_fan_drive, .cpu_fan_drive);
  sfc_fan_model sys_fan (.aclk, .drive(sys_fan_drive), .tach(sys_fan_tach_in));
  sfc_fan_model cpu_fan (.aclk, .drive(cpu_fan_drive), .tach(cpu_fan_tach_in));

  // Free-running 100 MHz clock.
  always #5 aclk = ~aclk;

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic hang(input string what);
    $display("unexpected %s exp done got stuck", what);
    error_cnt++;
    finish_test();
  endtask

  // One register write; both channels are offered together.
  task automatic wr(input logic [6:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= {23'h000000, idx, 2'h0};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid && n < 50);
    if (!bvalid)
      hang("write");
    `CHK("bresp", er, bresp)
    bready <= 1'b0;
  endtask

  // One register read, judged against the expected byte and response.
  task automatic rd(input logic [6:0] idx, input logic [7:0] ed,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= {23'h000000, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid && n < 50);
    if (!rvalid)
      hang("read");
    `CHK("rdata", {24'h000000, ed}, rdata)
    `CHK("rresp", er, rresp)
    rready <= 1'b0;
  endtask

  // Waits, bounded, until one drive shows the given level.
  task automatic wait_drv(input logic cpu, input logic [7:0] v);
    int n;
    n = 0;
    while ((cpu ? cpu_fan_drive : sys_fan_drive) !== v && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    if (n == 3000)
      hang("drive level");
  endtask

  task automatic t_regs();
    rd(7'h01, 8'hFF, 2'h0);
    rd(7'h03, 8'hFF, 2'h0);
    rd(7'h68, 8'h00, 2'h0);
    rd(7'h02, 8'h00, 2'h2);
    wr(7'h27, 8'h55, 2'h2);
    rd(7'h27, 8'h2A, 2'h0);
    wr(7'h01, 8'h40, 2'h0);
    `CHK("sys manual", 8'h40, sys_fan_drive)
  endtask

  task automatic t_hold();
    wr(7'h05, 8'h80, 2'h0);
    wr(7'h06, 8'h80, 2'h0);
    wr(7'h07, 8'h24, 2'h0);
    wr(7'h13, 8'h05, 2'h0);
    `CHK("sys start", 1'b1, sys_fan_drive inside {8'h40, 8'h41})
    wait_drv(1'b0, 8'h7B);
    wait_drv(1'b1, 8'h81);
    repeat (6 * UC) @(posedge aclk);
    `CHK("sys held", 8'h7B, sys_fan_drive)
    `CHK("cpu held", 8'h81, cpu_fan_drive)
  endtask

  task automatic t_step();
    int gap;
    wr(7'h13, 8'h00, 2'h0);
    wr(7'h06, 8'h32, 2'h0);
    wr(7'h49, 8'h03, 2'h0);
    wr(7'h67, 8'h90, 2'h0);
    wr(7'h68, 8'h10, 2'h0);
    wr(7'h03, 8'h60, 2'h0);
    wr(7'h13, 8'h08, 2'h0);
    repeat (10 * UC) @(posedge aclk);
    `CHK("cpu hold", 8'h60, cpu_fan_drive)
    `CHK("sys kept", 8'h7B, sys_fan_drive)
    temp_src_whole[3] <= 8'h35;
    wait_drv(1'b1, 8'h70);
    repeat (10 * UC) @(posedge aclk);
    `CHK("cpu shifted", 8'h70, cpu_fan_drive)
    wr(7'h0F, 8'h02, 2'h0);
    temp_src_whole[3] <= 8'hC8;
    wait_drv(1'b1, 8'h80);
    for (gap = 0; cpu_fan_drive === 8'h80 && gap < 100; gap++)
      @(posedge aclk);
    `CHK("pace", 1'b1, gap >= 2 * UC && gap <= 3 * UC)
    wait_drv(1'b1, 8'h90);
    repeat (10 * UC) @(posedge aclk);
    `CHK("cpu max", 8'h90, cpu_fan_drive)
    wr(7'h09, 8'h20, 2'h0);
    wr(7'h0D, 8'h05, 2'h0);
    wr(7'h12, 8'h10, 2'h0);
    temp_src_whole[3] <= 8'h00;
    wait_drv(1'b1, 8'h80);
    wait_drv(1'b1, 8'h20);
    rd(7'h14, 8'h03, 2'h0);
    repeat (8 * UC) @(posedge aclk);
    rd(7'h14, 8'h01, 2'h0);
    `CHK("cpu floor", 8'h20, cpu_fan_drive)
  endtask

  // Reset for eight cycles, then the scenarios in turn.
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, wdata, araddr} = 96'h0;
    temp_src_whole = {8{8'h64}};
    temp_src_whole[3] = 8'h32;
    error_cnt = 0;
    samples_checked = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_hold();
    t_step();
    finish_test();
  end

endmodule
